//--- acs_clk_div.sv
`timescale 1ns/100ps
// conversion clock enable: source select plus programmable divider
module acs_clk_div
	import acs_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	// configuration
	input wire logic [1:0] src_sel,
	input wire logic [1:0] div_sel,
	input wire logic busy,
	// source pulses and power state
	input wire logic local_tick,
	input wire logic alt_tick,
	input wire logic stop_any,
	// divided conversion clock enable
	output logic tick_q
);

	logic [1:0] src_q, src_d, div_q, div_d;
	logic half_q, half_d, tick_d;
	logic [2:0] cnt_q, cnt_d, cnt_max;
	logic pulse;

	// pick source, divide, latch settings only while idle
	always_comb
	begin
		src_d = busy ? src_q : src_sel; // R26
		div_d = busy ? div_q : div_sel; // R26
		half_d = ~half_q;
		cnt_max = 3'((4'h1 << div_q) - 4'h1); // R06
		unique case (src_q) // R04
			SRC_BUS: pulse = 1'b1;
			SRC_BUS_HALF: pulse = half_q;
			SRC_ALT: pulse = alt_tick & ~stop_any; // R05 R07 R08
			SRC_LOCAL: pulse = local_tick;
		endcase
		cnt_d = cnt_q;
		tick_d = 1'b0;
		if (pulse)
		begin
			// a count left above a smaller end value ticks at once, no stretched period
			tick_d = cnt_q >= cnt_max;
			cnt_d = tick_d ? 3'h0 : cnt_q + 3'h1;
		end
	end

	// registers
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			src_q <= SRC_BUS;
			div_q <= 2'h0;
			half_q <= 1'b0;
			cnt_q <= 3'h0;
			tick_q <= 1'b0;
		end
		else if (ce)
		begin
			src_q <= src_d;
			div_q <= div_d;
			half_q <= half_d;
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	chk_src_hold: assert property (@(posedge clock) disable iff (!rst_n) busy |=> $stable(src_q)) // R26
		else $error("clock source changed during a conversion");
	chk_alt_stop: assert property (@(posedge clock) disable iff (!rst_n) (src_q == SRC_ALT && stop_any) |-> !pulse) // R08
		else $error("alternate clock used in stop mode");

endmodule : acs_clk_div

//--- acs_front_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// analog front end and counter overflow
// ----------------------------------------
module acs_front_model
	import acs_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// bench controls
	input wire logic [9:0] level,
	input wire logic fire,
	// sequencer side
	input wire logic [9:0] trial_q,
	input wire logic converter_on_q,
	output logic cmp_above,
	output logic local_tick,
	output logic alt_tick,
	output logic overflow
);
	int lcnt_q;
	int acnt_q;
	int ocnt_q;
	logic junk_q;
	// local source every 5 cycles, external reference every 3
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lcnt_q <= 0;
			acnt_q <= 0;
			ocnt_q <= 0;
			junk_q <= 1'b0;
		end
		else
		begin
			lcnt_q <= (lcnt_q == 4) ? 0 : lcnt_q + 1;
			acnt_q <= (acnt_q == 2) ? 0 : acnt_q + 1;
			ocnt_q <= fire ? 2 : ((ocnt_q > 0) ? ocnt_q - 1 : 0);
			junk_q <= ~junk_q;
		end
	end
	// one-cycle source pulses
	assign local_tick = (lcnt_q == 4);
	assign alt_tick = (acnt_q == 2);
	// overflow held two cycles, never gated by an interrupt enable
	assign overflow = (ocnt_q > 0);
	// input at or above trial; meaningless toggling while off
	assign cmp_above = converter_on_q ? (level >= trial_q) : junk_q;
endmodule : acs_front_model

//--- acs_pkg.sv
package acs_pkg;

	// ----------------------------------------
	// register map (byte data, 3-bit address)
	// ----------------------------------------
	localparam logic [2:0] ADDR_CTRL1 = 3'h0;
	localparam logic [2:0] ADDR_CTRL2 = 3'h1;
	localparam logic [2:0] ADDR_RES_HI = 3'h2;
	localparam logic [2:0] ADDR_RES_LO = 3'h3;
	localparam logic [2:0] ADDR_CMP_HI = 3'h4;
	localparam logic [2:0] ADDR_CMP_LO = 3'h5;
	localparam logic [2:0] ADDR_CFG = 3'h6;

	// first status/control fields
	localparam int CTRL1_DONE_BIT = 7;
	localparam int CTRL1_IEN_BIT = 6;
	localparam int CTRL1_CONT_BIT = 5;
	localparam logic [7:0] CTRL1_RST = 8'h1F;
	// second status/control fields
	localparam int CTRL2_BUSY_BIT = 7;
	localparam int CTRL2_HWT_BIT = 6;
	localparam int CTRL2_CMPEN_BIT = 5;
	localparam int CTRL2_CMPGE_BIT = 4;
	localparam logic [2:0] CTRL2_RST = 3'h0;
	// configuration fields
	localparam int CFG_LP_BIT = 7;
	localparam int CFG_DIV_LSB = 5;
	localparam int CFG_LONG_BIT = 4;
	localparam int CFG_MODE10_BIT = 3;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [9:0] CMP_RST = 10'h000;

	// ----------------------------------------
	// channel codes and clock sources
	// ----------------------------------------
	localparam logic [4:0] CH_EXT_LAST = 5'h0B;
	localparam logic [4:0] CH_GND_LAST = 5'h14;
	localparam logic [4:0] CH_TEMP = 5'h1A;
	localparam logic [4:0] CH_BANDGAP = 5'h1B;
	localparam logic [4:0] CH_OFF = 5'h1F;
	localparam logic [1:0] SRC_BUS = 2'h0;
	localparam logic [1:0] SRC_BUS_HALF = 2'h1;
	localparam logic [1:0] SRC_ALT = 2'h2;
	localparam logic [1:0] SRC_LOCAL = 2'h3;

	// ----------------------------------------
	// timing in conversion clock periods, last bit index and first trial code
	// ----------------------------------------
	localparam logic [4:0] SAMPLE_SHORT = 5'h03;
	localparam logic [4:0] SAMPLE_LONG = 5'h13;
	localparam logic [3:0] SAR_LAST_BIT = 4'h9;
	localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;

	// channel code that turns the converter off
	function automatic logic chan_off(input logic [4:0] code);
		return code == CH_OFF;
	endfunction : chan_off

	// one-hot select of the twelve external pins
	function automatic logic [11:0] chan_pins(input logic [4:0] code);
		logic [11:0] sel;
		sel = 12'h000;
		if (code <= CH_EXT_LAST)
			sel[code[3:0]] = 1'b1;
		return sel;
	endfunction : chan_pins

endpackage : acs_pkg

//--- acs_sar.sv
`timescale 1ns/100ps
// successive approximation register, one bit per conversion tick
module acs_sar
	import acs_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	// control
	input wire logic start,
	input wire logic abort,
	input wire logic tick,
	input wire logic cmp_above,
	// outputs
	output logic [9:0] trial_q,
	output logic [9:0] result_q,
	output logic done_q,
	output logic busy_q
);

	logic [9:0] trial_d, result_d;
	logic [3:0] idx_q, idx_d;
	logic done_d, busy_d;

	// resolve bit idx from the comparator, then try the next one
	always_comb
	begin
		trial_d = trial_q;
		result_d = result_q;
		idx_d = idx_q;
		busy_d = busy_q;
		done_d = 1'b0;
		if (abort)
			busy_d = 1'b0;
		else if (start)
		begin
			trial_d = SAR_FIRST_TRIAL;
			idx_d = SAR_LAST_BIT;
			busy_d = 1'b1;
		end
		else if (busy_q && tick) // R13
		begin
			trial_d[idx_q] = cmp_above;
			if (idx_q == 4'h0)
			begin
				result_d = trial_d;
				busy_d = 1'b0;
				done_d = 1'b1;
			end
			else
			begin
				idx_d = idx_q - 4'h1;
				trial_d[idx_d] = 1'b1;
			end
		end
	end

	// registers
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			trial_q <= 10'h000;
			result_q <= 10'h000;
			idx_q <= 4'h0;
			done_q <= 1'b0;
			busy_q <= 1'b0;
		end
		else if (ce)
		begin
			trial_q <= trial_d;
			result_q <= result_d;
			idx_q <= idx_d;
			done_q <= done_d;
			busy_q <= busy_d;
		end
	end

	// helper: count resolved bits of the current conversion
	logic [4:0] steps_q;
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			steps_q <= 5'h00;
		else if (ce && start)
			steps_q <= 5'h00;
		else if (ce && busy_q && tick)
			steps_q <= steps_q + 5'h01;
	end

	chk_ten_steps: assert property (@(posedge clock) disable iff (!rst_n) $rose(done_q) |-> steps_q == 5'h0A) // R13
		else $error("conversion did not resolve ten bits");

endmodule : acs_sar

//--- acs_sequencer.sv
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/100ps
// ----------------------------------------
// How it works
// R01: decode channel code to pins, ground, sensors, off
// R02: reserved channel codes give undefined results
// R03: software enables bandgap buffer before bandgap channel
// R04: conversion clock from one of four sources
// R05: alternate clock is the external reference clock
// R06: divider field scales the selected source
// R07: alternate clock keeps running in wait mode
// R08: alternate clock unusable in stop modes
// R09: hardware trigger comes from real time counter
// R10: counter overflow starts conversion when trigger enabled
// R11: trigger works regardless of counter interrupt enable
// R12: hardware trigger works in run, wait, shallow stop
// R13: ten result bits, one per approximation step
// R14: result right-justified, ten or eight bits
// R15: single conversion idles, continuous repeats
// R16: conversion done flag with interrupt request
// R17: optional less-than or greater-equal compare
// R18: sample time and power trade-off configurable
// R19: conversions continue in wait and shallow stop
// R20: channel select addresses up to 28 inputs
// R21: temperature reading: long sample, slow clock, bandgap first
// R22: first control write aborts and restarts unless off; code restarts only with hardware trigger off
// R23: done flag cleared by control write, low read
// R24: with compare on, done set only when true
// R25: counter overflow synchronised, one start per overflow
// R26: clock source switches only while idle
// ----------------------------------------
module acs_sequencer
	import acs_pkg::*;
(
	// clock, reset, clock enable
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	// register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_q,
	// triggers and clock sources
	input wire logic hardware_trigger_input,
	input wire logic local_async_conversion_clock,
	input wire logic alternate_clock_input,
	// processor power state
	input wire logic wait_mode,
	input wire logic stop2_mode,
	input wire logic stop3_mode,
	// analog front end
	input wire logic cmp_above,
	output logic [4:0] channel_q,
	output logic [11:0] pin_select_q,
	output logic temp_select_q,
	output logic bandgap_select_q,
	output logic sample_en_q,
	output logic [9:0] trial_q,
	output logic converter_on_q,
	output logic low_power_q,
	// conversion complete request
	output logic irq_q
);

	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} acs_state_t;

	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic [4:0] chan_q, chan_d;
	logic ien_q, ien_d, cont_q, cont_d, done_q, done_d;
	logic hwt_q, hwt_d, cmpen_q, cmpen_d, cmpge_q, cmpge_d;
	logic [7:0] cfg_q, cfg_d;
	logic [9:0] cmp_q, cmp_d, res_q, res_d;
	logic [7:0] rdata_d;
	logic wr_ctrl1, rd_res_lo;

	// ----------------------------------------
	// sequencer state
	// ----------------------------------------
	acs_state_t state_q, state_d;
	logic [4:0] samp_q, samp_d;
	logic trig_prev_q, trig_pend_q, trig_pend_d;
	logic sar_start, sar_abort, sar_done, sar_busy, tick, finish, cmp_true;
	logic [9:0] sar_res, fmt_res;
	logic [4:0] samp_len;

	assign wr_ctrl1 = reg_wr && reg_addr == ADDR_CTRL1;
	assign rd_res_lo = reg_rd && reg_addr == ADDR_RES_LO;

	// conversion clock: four sources through the divider
	acs_clk_div u_clk_div (
		.clock(clock),
		.rst_n(rst_n),
		.ce(ce),
		.src_sel(cfg_q[1:0]), // R04
		.div_sel(cfg_q[CFG_DIV_LSB +: 2]), // R06
		.busy(state_q != ST_IDLE), // R26
		.local_tick(local_async_conversion_clock),
		.alt_tick(alternate_clock_input), // R05
		.stop_any(stop2_mode | stop3_mode), // R08
		.tick_q(tick)
	);

	// approximation engine
	acs_sar u_sar (
		.clock(clock),
		.rst_n(rst_n),
		.ce(ce),
		.start(sar_start),
		.abort(sar_abort),
		.tick(tick),
		.cmp_above(cmp_above),
		.trial_q(trial_q), // engine flop feeds the dac, comparator settles before the next tick
		.result_q(sar_res),
		.done_q(sar_done),
		.busy_q(sar_busy)
	);

	// ----------------------------------------
	// result format and compare
	// ----------------------------------------
	always_comb
	begin
		// eight-bit mode keeps the top eight bits, right-justified
		fmt_res = cfg_q[CFG_MODE10_BIT] ? sar_res : {2'b00, sar_res[9:2]}; // R14
		cmp_true = cmpge_q ? (fmt_res >= cmp_q) : (fmt_res < cmp_q); // R17
		finish = state_q == ST_CONVERT && sar_done;
		samp_len = cfg_q[CFG_LONG_BIT] ? SAMPLE_LONG : SAMPLE_SHORT; // R18
	end

	// ----------------------------------------
	// conversion sequence
	// ----------------------------------------
	always_comb
	begin
		state_d = state_q;
		samp_d = samp_q;
		sar_start = 1'b0;
		sar_abort = 1'b0;
		// overflow edge held until a conversion tick takes it
		trig_pend_d = trig_pend_q;
		if (hardware_trigger_input && !trig_prev_q) // R09 R11 R12
			trig_pend_d = 1'b1; // R25
		else if (state_q == ST_IDLE && tick && hwt_q)
			trig_pend_d = 1'b0; // R25
		if (!hwt_q)
			trig_pend_d = 1'b0;
		if (wr_ctrl1 && ce)
		begin
			// abort whatever runs, restart in software mode
			sar_abort = 1'b1; // R22
			samp_d = 5'h00;
			state_d = (chan_off(reg_wdata[4:0]) || hwt_q) ? ST_IDLE : ST_SAMPLE; // R22
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
					if (tick && hwt_q && trig_pend_q && !chan_off(chan_q))
					begin
						state_d = ST_SAMPLE; // R10
						samp_d = 5'h00;
					end
				ST_SAMPLE:
					if (tick)
					begin
						samp_d = samp_q + 5'h01;
						if (samp_q == samp_len)
						begin
							sar_start = 1'b1;
							state_d = ST_CONVERT;
						end
					end
				ST_CONVERT:
					if (sar_done)
					begin
						samp_d = 5'h00;
						// continuous restarts back to back
						state_d = (cont_q && !chan_off(chan_q)) ? ST_SAMPLE : ST_IDLE; // R15
					end
				default:
					state_d = ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// register writes, flag and read data
	// ----------------------------------------
	always_comb
	begin
		chan_d = chan_q;
		ien_d = ien_q;
		cont_d = cont_q;
		hwt_d = hwt_q;
		cmpen_d = cmpen_q;
		cmpge_d = cmpge_q;
		cfg_d = cfg_q;
		cmp_d = cmp_q;
		res_d = res_q;
		done_d = done_q;
		if (reg_wr)
		begin
			unique case (reg_addr)
				ADDR_CTRL1:
				begin
					chan_d = reg_wdata[4:0]; // R01 R20
					ien_d = reg_wdata[CTRL1_IEN_BIT];
					cont_d = reg_wdata[CTRL1_CONT_BIT];
				end
				ADDR_CTRL2:
				begin
					hwt_d = reg_wdata[CTRL2_HWT_BIT];
					cmpen_d = reg_wdata[CTRL2_CMPEN_BIT];
					cmpge_d = reg_wdata[CTRL2_CMPGE_BIT];
				end
				ADDR_CMP_HI: cmp_d[9:8] = reg_wdata[1:0];
				ADDR_CMP_LO: cmp_d[7:0] = reg_wdata;
				ADDR_CFG: cfg_d = reg_wdata; // R18
				default: cfg_d = cfg_q;
			endcase
		end
		// clear by control write or low-byte read; completion wins
		if (wr_ctrl1 || rd_res_lo)
			done_d = 1'b0; // R23
		if (finish)
		begin
			res_d = fmt_res; // R02
			if (!cmpen_q || cmp_true)
				done_d = 1'b1; // R16 R24
		end
		unique case (reg_addr)
			ADDR_CTRL1: rdata_d = {done_q, ien_q, cont_q, chan_q};
			ADDR_CTRL2: rdata_d = {state_q != ST_IDLE, hwt_q, cmpen_q, cmpge_q, 4'h0};
			ADDR_RES_HI: rdata_d = {6'h00, res_q[9:8]};
			ADDR_RES_LO: rdata_d = res_q[7:0];
			ADDR_CMP_HI: rdata_d = {6'h00, cmp_q[9:8]};
			ADDR_CMP_LO: rdata_d = cmp_q[7:0];
			ADDR_CFG: rdata_d = cfg_q;
			default: rdata_d = 8'h00;
		endcase
		if (!reg_rd)
			rdata_d = 8'h00;
	end

	// ----------------------------------------
	// registers; conversions run on in wait and shallow stop
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) // R19
	begin
		if (!rst_n)
		begin
			chan_q <= CTRL1_RST[4:0];
			ien_q <= CTRL1_RST[CTRL1_IEN_BIT];
			cont_q <= CTRL1_RST[CTRL1_CONT_BIT];
			done_q <= CTRL1_RST[CTRL1_DONE_BIT];
			{hwt_q, cmpen_q, cmpge_q} <= CTRL2_RST;
			cfg_q <= CFG_RST;
			cmp_q <= CMP_RST;
			res_q <= 10'h000;
			reg_rdata_q <= 8'h00;
			state_q <= ST_IDLE;
			samp_q <= 5'h00;
			trig_prev_q <= 1'b0;
			trig_pend_q <= 1'b0;
		end
		else if (ce)
		begin
			chan_q <= chan_d;
			ien_q <= ien_d;
			cont_q <= cont_d;
			done_q <= done_d;
			{hwt_q, cmpen_q, cmpge_q} <= {hwt_d, cmpen_d, cmpge_d};
			cfg_q <= cfg_d;
			cmp_q <= cmp_d;
			res_q <= res_d;
			reg_rdata_q <= rdata_d;
			state_q <= state_d;
			samp_q <= samp_d;
			trig_prev_q <= hardware_trigger_input;
			trig_pend_q <= trig_pend_d;
		end
	end

	// analog side outputs, all registered
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			channel_q <= CH_OFF;
			pin_select_q <= 12'h000;
			temp_select_q <= 1'b0;
			bandgap_select_q <= 1'b0;
			sample_en_q <= 1'b0;
			converter_on_q <= 1'b0;
			low_power_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else if (ce)
		begin
			channel_q <= chan_d; // R20
			pin_select_q <= chan_pins(chan_d); // R01
			temp_select_q <= chan_d == CH_TEMP; // R01
			bandgap_select_q <= chan_d == CH_BANDGAP; // R01
			sample_en_q <= state_d == ST_SAMPLE;
			converter_on_q <= state_d != ST_IDLE; // R01
			low_power_q <= cfg_d[CFG_LP_BIT]; // R18
			irq_q <= done_d && ien_d; // R16
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_sw_start;
		ce && wr_ctrl1 && !chan_off(reg_wdata[4:0]) && !hwt_q;
	endsequence
	sequence s_sample_then_convert;
		(state_q == ST_SAMPLE) ##1 (state_q == ST_SAMPLE || state_q == ST_CONVERT);
	endsequence

	chk_write_restart: assert property (s_sw_start |-> ##1 s_sample_then_convert) // R22
		else $error("control write did not restart a conversion");
	chk_off_no_start: assert property (ce && wr_ctrl1 && chan_off(reg_wdata[4:0]) |=> state_q == ST_IDLE) // R22
		else $error("conversion started with channel off");
	chk_write_clears: assert property (ce && (wr_ctrl1 || rd_res_lo) && !finish |=> !done_q) // R23
		else $error("done flag not cleared");
	chk_done_sets: assert property (ce && finish && (!cmpen_q || cmp_true) |=> done_q) // R16
		else $error("done flag not set on completion");
	chk_cmp_gate: assert property (ce && finish && cmpen_q && !cmp_true && !done_q |=> !done_q) // R24
		else $error("done flag set with compare false");
	chk_irq_follow: assert property (ce && done_q && ien_q && !reg_wr && !reg_rd |=> irq_q) // R16
		else $error("interrupt request missing");
	chk_single_idle: assert property (ce && finish && !cont_q && !reg_wr |=> state_q == ST_IDLE) // R15
		else $error("single conversion did not return to idle");
	chk_cont_again: assert property (ce && finish && cont_q && !chan_off(chan_q) && !reg_wr |=> state_q == ST_SAMPLE) // R15
		else $error("continuous conversion did not repeat");
	chk_trig_start: assert property (ce && state_q == ST_IDLE && tick && hwt_q && trig_pend_q // R10 R25
		&& !chan_off(chan_q) && !reg_wr && !(hardware_trigger_input && !trig_prev_q)
		|=> state_q == ST_SAMPLE && !trig_pend_q)
		else $error("counter overflow did not start a conversion");
	chk_eight_bit: assert property (ce && finish && !cfg_q[CFG_MODE10_BIT] |=> res_q[9:8] == 2'b00) // R14
		else $error("eight-bit result not right-justified");

endmodule : acs_sequencer

//--- tb_adc_conversion_sequencer.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
	$display("BAD %s exp %0h got %0h", nm, e, g); mismatches++; end end
// ----------------------------------------
// self-checking bench
// ----------------------------------------
module tb_adc_conversion_sequencer
	import acs_pkg::*;
;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic wait_mode = 1'b0;
	logic stop2_mode = 1'b0;
	logic stop3_mode = 1'b0;
	logic fire = 1'b0;
	logic [9:0] level = 10'h000;
	logic [7:0] reg_rdata_q;
	logic trig, local_tick, alt_tick, cmp_above, temp_select_q, bandgap_select_q;
	logic sample_en_q, converter_on_q, low_power_q, irq_q;
	logic [4:0] channel_q;
	logic [11:0] pin_select_q;
	logic [9:0] trial_q;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [31:0] seed = 32'he763_18b6;
	// 8 ns clock
	always #4 clock = ~clock;
	acs_sequencer u_dut (.clock(clock), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.hardware_trigger_input(trig), .local_async_conversion_clock(local_tick),
		.alternate_clock_input(alt_tick), .wait_mode(wait_mode), .stop2_mode(stop2_mode),
		.stop3_mode(stop3_mode), .cmp_above(cmp_above), .channel_q(channel_q),
		.pin_select_q(pin_select_q), .temp_select_q(temp_select_q),
		.bandgap_select_q(bandgap_select_q), .sample_en_q(sample_en_q), .trial_q(trial_q),
		.converter_on_q(converter_on_q), .low_power_q(low_power_q), .irq_q(irq_q));
	acs_front_model u_front (.clock(clock), .rst_n(rst_n), .level(level), .fire(fire),
		.trial_q(trial_q), .converter_on_q(converter_on_q), .cmp_above(cmp_above),
		.local_tick(local_tick), .alt_tick(alt_tick), .overflow(trig));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// result in the selected format
	function automatic logic [9:0] exp_res(input logic [9:0] v, input logic m10);
		return m10 ? v : {2'b00, v[9:2]};
	endfunction : exp_res
	// compare outcome
	function automatic logic exp_hit(input logic [9:0] v, input logic [9:0] c, input logic ge);
		return ge ? (v >= c) : (v < c);
	endfunction : exp_hit
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata_q;
	endtask : rd
	// start: interrupt enabled, given channel and continuous bit
	task automatic conv(input logic [4:0] ch, input logic cont);
		wr(ADDR_CTRL1, {2'b01, cont, ch});
	endtask : conv
	task automatic wait_irq(input int lim, output int n);
		n = 0;
		#1;
		while (irq_q !== 1'b1 && n < lim)
		begin
			@(posedge clock);
			#1 n++;
		end
	endtask : wait_irq
	task automatic chk_res(input logic m10);
		logic [7:0] hi;
		logic [7:0] lo;
		rd(ADDR_RES_HI, hi);
		rd(ADDR_RES_LO, lo);
		`CHK("result", exp_res(level, m10), {hi[1:0], lo})
		@(posedge clock);
		#1 `CHK("irq after low read", 1'b0, irq_q)
	endtask : chk_res
	// one single conversion, timed against ticks of p cycles
	task automatic run(input logic [7:0] cfg, input int p);
		int n;
		int t;
		t = cfg[CFG_LONG_BIT] ? 30 : 14;
		level = 10'(rnd());
		wr(ADDR_CFG, cfg);
		conv(5'(rnd() % 12), 1'b0);
		wait_irq(4000, n);
		`CHK("time min", 1'b1, n >= (t - 1) * p + 2)
		`CHK("time max", 1'b1, n <= (t + 1) * p + 8)
		`CHK("low power", cfg[CFG_LP_BIT], low_power_q)
		chk_res(cfg[CFG_MODE10_BIT]);
		`CHK("idle after single", 1'b0, converter_on_q)
	endtask : run
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	// hang guard
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			mismatches++;
			wrap_up();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		logic [7:0] d;
		logic [9:0] v;
		logic [9:0] cv;
		logic [31:0] r;
		int n;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		// reset values, unmapped address, strobe without ce
		rd(ADDR_CTRL1, d);
		`CHK("ctrl1 reset", CTRL1_RST, d)
		rd(ADDR_CFG, d);
		`CHK("cfg reset", CFG_RST, d)
		rd(3'h7, d);
		`CHK("unmapped", 8'h00, d)
		`CHK("off at reset", CH_OFF, channel_q)
		ce <= 1'b0;
		wr(ADDR_CFG, 8'h80);
		ce <= 1'b1;
		@(posedge clock);
		#1 `CHK("write without ce", 1'b0, low_power_q)
		// every channel code; each write aborts, and restarts unless the code is off
		wr(ADDR_CFG, 8'h08);
		for (int c = 0; c < 32; c++)
		begin
			conv(5'(c), 1'b0);
			repeat (2) @(posedge clock);
			#1 `CHK("channel", 5'(c), channel_q)
			`CHK("pins", (c <= 11) ? (12'h001 << c) : 12'h000, pin_select_q)
			`CHK("temp sel", c == 26, temp_select_q)
			`CHK("bandgap sel", c == 27, bandgap_select_q)
			`CHK("converter on", c != 31, converter_on_q)
			`CHK("sampling", c != 31, sample_en_q)
		end
		// all sources and dividers, random format, sample length, power
		for (int s = 0; s < 4; s++)
			for (int k = 0; k < 4; k++)
			begin
				r = rnd();
				run({r[0], 2'(k), r[1], r[2], 1'b0, 2'(s)}, ((s == 0) ? 1 : (s == 1) ? 2 : (s == 2) ? 3 : 5) << k);
			end
		// alternate source unusable in stop2 and stop3
		wr(ADDR_CFG, 8'h0A);
		for (int k = 0; k < 2; k++)
		begin
			stop2_mode <= (k == 0);
			stop3_mode <= (k == 1);
			conv(5'h01, 1'b0);
			wait_irq(300, n);
			`CHK("alt in stop", 1'b0, irq_q)
		end
		stop2_mode <= 1'b0;
		stop3_mode <= 1'b0;
		wait_mode <= 1'b1;
		level = 10'h3FF;
		conv(5'h01, 1'b0);
		wait_irq(300, n);
		`CHK("alt in wait", 1'b1, irq_q)
		chk_res(1'b1);
		stop3_mode <= 1'b1;
		level = 10'h000;
		wr(ADDR_CFG, 8'h08);
		conv(5'h00, 1'b0);
		wait_irq(100, n);
		`CHK("bus in shallow stop", 1'b1, irq_q)
		chk_res(1'b1);
		// hardware trigger: write only arms, each overflow one start
		wr(ADDR_CTRL2, 8'h40);
		conv(5'h02, 1'b0);
		wait_irq(100, n);
		`CHK("no start on write", 1'b0, irq_q)
		for (int k = 0; k < 2; k++)
		begin
			stop3_mode <= (k == 1);
			level = 10'(rnd());
			fire <= 1'b1;
			@(posedge clock);
			fire <= 1'b0;
			wait_irq(200, n);
			`CHK("trigger start", 1'b1, irq_q)
			chk_res(1'b1);
			wait_irq(200, n);
			`CHK("one start per overflow", 1'b0, irq_q)
		end
		stop3_mode <= 1'b0;
		wait_mode <= 1'b0;
		// compare both senses, equal value included
		for (int k = 0; k < 4; k++)
		begin
			v = 10'(rnd());
			cv = k[1] ? v : 10'(rnd());
			level = v;
			wr(ADDR_CMP_HI, {6'h00, cv[9:8]});
			wr(ADDR_CMP_LO, cv[7:0]);
			wr(ADDR_CTRL2, {2'b00, 1'b1, k[0], 4'h0});
			conv(5'h03, 1'b0);
			wait_irq(100, n);
			`CHK("compare flag", exp_hit(v, cv, k[0]), irq_q)
		end
		wr(ADDR_CTRL2, 8'h00);
		// continuous conversion, then off code
		level = 10'h155;
		conv(5'h04, 1'b1);
		wait_irq(100, n);
		chk_res(1'b1);
		wait_irq(100, n);
		`CHK("continuous next", 1'b1, irq_q)
		wr(ADDR_CTRL1, 8'h7F);
		repeat (100) @(posedge clock);
		#1 `CHK("off stops converter", 1'b0, converter_on_q)
		rd(ADDR_RES_LO, d);
		repeat (60) @(posedge clock);
		#1 `CHK("no more conversions", 1'b0, irq_q)
		// divider change while busy waits for idle
		level = 10'h2AA;
		conv(5'h05, 1'b0);
		wr(ADDR_CFG, 8'hE8);
		wait_irq(200, n);
		`CHK("source held while busy", 1'b1, n <= 24)
		conv(5'h06, 1'b0);
		@(posedge clock);
		#1 `CHK("write clears done", 1'b0, irq_q)
		repeat (40) @(posedge clock);
		level = 10'h0F0;
		conv(5'h07, 1'b0);
		wait_irq(400, n);
		`CHK("restart full length", 1'b1, n >= 13 * 8 + 2)
		chk_res(1'b1);
		// temperature reading: long sample, slow clock, bandgap channel first
		wr(ADDR_CFG, 8'h7B);
		for (int k = 0; k < 2; k++)
		begin
			level = 10'(rnd());
			conv(k ? CH_TEMP : CH_BANDGAP, 1'b0);
			wait_irq(2000, n);
			chk_res(1'b1);
		end
		wrap_up();
	end
endmodule : tb_adc_conversion_sequencer
